// file: logic/resp_gpio_pkg.sv
`default_nettype none
package resp_gpio_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] RESP_FIRST_IDX  = 6'h09;
  localparam logic [5:0] RESP_SECOND_IDX = 6'h0A;
  localparam logic [5:0] PIN_CTRL_IDX    = 6'h0B;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MODE_SEL_BIT   = 0;
  localparam int FIRST_ONE_BIT  = 1;
  localparam int PHASE_LSB      = 2;
  localparam int PHASE_W        = 4;
  localparam int SECOND_ONE_BIT = 0;
  localparam int REF_INT_BIT    = 1;
  localparam int FREQ_SEL_BIT   = 2;
  localparam int CAL_EN_BIT     = 7;
  localparam int PIN_DATA_LSB   = 0;
  localparam int PIN_DIR_LSB    = 2;
  localparam int PIN_COUNT      = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [3:0] PHASE_RST     = 4'h0;
  localparam logic       MODE_SEL_RST  = 1'b0;
  localparam logic       CAL_EN_RST    = 1'b0;
  localparam logic       FREQ_SEL_RST  = 1'b0;
  localparam logic       REF_INT_RST   = 1'b1;
  localparam logic [1:0] PIN_DIR_RST   = 2'h3;
  localparam logic [1:0] PIN_DRIVE_RST = 2'h0;

  // Phase step counts, in units of 11.25 degrees
  localparam int PHASE_STEP_W = 5;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

endpackage
`default_nettype wire

// file: logic/gpio_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gpio_pin_if #(parameter int WIDTH = 2);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface
`default_nettype wire

// file: logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Pin levels
  gpio_pin_if.sync  pins
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_level;

  // First stage feeds only the second stage
  always_comb begin
    nxt_meta  = pins.raw;
    nxt_level = meta_ff;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff  <= '0;
      level_ff <= '0;
    end else begin
      meta_ff  <= nxt_meta;
      level_ff <= nxt_level;
    end
  end

  assign pins.level = level_ff;

endmodule
`default_nettype wire

// file: logic/respiration_gpio_config.sv
`timescale 1ns/1ps
`default_nettype none
module respiration_gpio_config
  import resp_gpio_pkg::*;
#(
  parameter int NUM_PINS = PIN_COUNT
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  // Avalon-MM slave
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output var  logic [31:0]             avs_readdata,
  output var  logic                    avs_waitrequest,
  // Respiration enables from the rest of the unit
  input  wire logic                    respModEn,
  input  wire logic                    respDemodEn,
  // Respiration controls
  output var  logic                    offsetCalEnable,
  output var  logic                    modClk64k,
  output var  logic                    externalRespClock,
  output var  logic                    legDriveRefInternal,
  output var  logic [PHASE_STEP_W-1:0] demodPhaseSteps,
  output var  logic                    demodPhaseUnavail,
  // General-purpose pins
  input  wire logic [NUM_PINS-1:0]     gpioIn,
  output var  logic [NUM_PINS-1:0]     gpioOut,
  output var  logic [NUM_PINS-1:0]     gpioOe,
  output var  logic                    pinsTakenOver
);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  // Pins are asynchronous; nothing reads them before two flops
  gpio_pin_if #(.WIDTH(NUM_PINS)) pinBus ();

  assign pinBus.raw = gpioIn;

  pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pins     (pinBus)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Unaligned byte addresses match no register and read zero
  function automatic logic hits(input logic [7:0] addr,
                                input logic [5:0] idx);
    hits = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
  endfunction

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  bus_state_t  busState_ff;
  bus_state_t  nxt_busState;
  logic        waitReq_ff;
  logic        nxt_waitReq;
  logic [31:0] readData_ff;
  logic [31:0] nxt_readData;
  logic        wrCommit;

  logic [3:0]          phaseCode_ff;
  logic                modeSel_ff;
  logic                calEnable_ff;
  logic                freqSel_ff;
  logic                refInternal_ff;
  logic [NUM_PINS-1:0] pinDir_ff;
  logic [NUM_PINS-1:0] pinDrive_ff;

  // Read image assembled from live state
  logic [7:0] firstImage;
  logic [7:0] secondImage;
  logic [7:0] pinImage;

  always_comb begin
    firstImage                             = 8'h00;
    firstImage[MODE_SEL_BIT]               = modeSel_ff;
    firstImage[FIRST_ONE_BIT]              = 1'b1;
    firstImage[PHASE_LSB +: PHASE_W]       = phaseCode_ff;
    secondImage                            = 8'h00;
    secondImage[SECOND_ONE_BIT]            = 1'b1;
    secondImage[REF_INT_BIT]               = refInternal_ff;
    secondImage[FREQ_SEL_BIT]              = freqSel_ff;
    secondImage[CAL_EN_BIT]                = calEnable_ff;
    pinImage                               = 8'h00;
    pinImage[PIN_DIR_LSB +: NUM_PINS]      = pinDir_ff;
    pinImage[PIN_DATA_LSB +: NUM_PINS]     = pinBus.level;
  end

  // One wait cycle: request seen, then waitrequest drops for one cycle
  always_comb begin
    nxt_busState = busState_ff;
    nxt_waitReq  = 1'b1;
    nxt_readData = readData_ff;
    wrCommit     = 1'b0;
    unique case (busState_ff)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_busState = BUS_ACK;
          nxt_waitReq  = 1'b0;
          // Writes and unmapped reads leave zero on the data bus
          nxt_readData = 32'h0000_0000;
          if (avs_read) begin
            if (hits(avs_address, RESP_FIRST_IDX)) begin
              nxt_readData[7:0] = firstImage;
            end else if (hits(avs_address, RESP_SECOND_IDX)) begin
              nxt_readData[7:0] = secondImage;
            end else if (hits(avs_address, PIN_CTRL_IDX)) begin
              nxt_readData[7:0] = pinImage;
            end
          end
        end
      end
      BUS_ACK: begin
        // Write lands at the edge where the master sees waitrequest low
        nxt_busState = BUS_IDLE;
        wrCommit     = avs_write && avs_byteenable[0];
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busState_ff <= BUS_IDLE;
      waitReq_ff  <= 1'b1;
      readData_ff <= 32'h0000_0000;
    end else begin
      busState_ff <= nxt_busState;
      waitReq_ff  <= nxt_waitReq;
      readData_ff <= nxt_readData;
    end
  end

  assign avs_waitrequest = waitReq_ff;
  assign avs_readdata    = readData_ff;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [3:0]          nxt_phaseCode;
  logic                nxt_modeSel;
  logic                nxt_calEnable;
  logic                nxt_freqSel;
  logic                nxt_refInternal;
  logic [NUM_PINS-1:0] nxt_pinDir;
  logic [NUM_PINS-1:0] nxt_pinDrive;
  logic [7:0]          wrByte;

  // Fixed bits are not stored; they read back at their fixed values
  // Nothing checks that software writes the fixed values
  always_comb begin
    wrByte          = avs_writedata[7:0];
    nxt_phaseCode   = phaseCode_ff;
    nxt_modeSel     = modeSel_ff;
    nxt_calEnable   = calEnable_ff;
    nxt_freqSel     = freqSel_ff;
    nxt_refInternal = refInternal_ff;
    nxt_pinDir      = pinDir_ff;
    nxt_pinDrive    = pinDrive_ff;
    if (wrCommit && hits(avs_address, RESP_FIRST_IDX)) begin
      nxt_phaseCode = wrByte[PHASE_LSB +: PHASE_W];
      nxt_modeSel   = wrByte[MODE_SEL_BIT];
    end
    if (wrCommit && hits(avs_address, RESP_SECOND_IDX)) begin
      nxt_calEnable   = wrByte[CAL_EN_BIT];
      nxt_freqSel     = wrByte[FREQ_SEL_BIT];
      nxt_refInternal = wrByte[REF_INT_BIT];
    end
    if (wrCommit && hits(avs_address, PIN_CTRL_IDX)) begin
      nxt_pinDir = wrByte[PIN_DIR_LSB +: NUM_PINS];
      for (int i = 0; i < NUM_PINS; i++) begin
        // Direction in force before this write decides
        if (!pinDir_ff[i]) begin
          nxt_pinDrive[i] = wrByte[PIN_DATA_LSB + i];
        end
        // Input pins keep the old drive value
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phaseCode_ff   <= PHASE_RST;
      modeSel_ff     <= MODE_SEL_RST;
      calEnable_ff   <= CAL_EN_RST;
      freqSel_ff     <= FREQ_SEL_RST;
      refInternal_ff <= REF_INT_RST;
      pinDir_ff      <= PIN_DIR_RST;
      pinDrive_ff    <= PIN_DRIVE_RST;
    end else begin
      phaseCode_ff   <= nxt_phaseCode;
      modeSel_ff     <= nxt_modeSel;
      calEnable_ff   <= nxt_calEnable;
      freqSel_ff     <= nxt_freqSel;
      refInternal_ff <= nxt_refInternal;
      pinDir_ff      <= nxt_pinDir;
      pinDrive_ff    <= nxt_pinDrive;
    end
  end

  // ****************************************************************
  // Register outputs
  // ****************************************************************
  assign offsetCalEnable     = calEnable_ff;
  assign legDriveRefInternal = refInternal_ff;

  // ****************************************************************
  // Derived controls
  // ****************************************************************
  logic                    fast_ff;
  logic                    extClk_ff;
  logic [PHASE_STEP_W-1:0] steps_ff;
  logic                    unavail_ff;
  logic [NUM_PINS-1:0]     pinOut_ff;
  logic [NUM_PINS-1:0]     pinOe_ff;
  logic                    taken_ff;
  logic                    nxt_fast;
  logic                    nxt_extClk;
  logic [PHASE_STEP_W-1:0] nxt_steps;
  logic                    nxt_unavail;
  logic [NUM_PINS-1:0]     nxt_pinOut;
  logic [NUM_PINS-1:0]     nxt_pinOe;
  logic                    nxt_taken;

  // One cycle of lag keeps every output straight from a flop
  // Frequency bit only matters under internal clocking
  always_comb begin
    nxt_extClk = modeSel_ff;
    nxt_fast   = !modeSel_ff && freqSel_ff;
    // 32 kHz: one 11.25 degree step per code; 64 kHz: 22.5 degree steps
    // Top code bit is ignored at 64 kHz; those codes are flagged
    if (nxt_fast) begin
      nxt_steps   = {1'b0, phaseCode_ff[2:0], 1'b0};
      nxt_unavail = phaseCode_ff[3];
    end else begin
      nxt_steps   = {1'b0, phaseCode_ff};
      nxt_unavail = 1'b0;
    end
    // Externally clocked respiration owns the pins while it runs
    // Register contents survive a takeover; only the drive is masked
    nxt_taken = modeSel_ff && (respModEn || respDemodEn);
    for (int i = 0; i < NUM_PINS; i++) begin
      nxt_pinOe[i]  = !nxt_taken && !pinDir_ff[i];
      nxt_pinOut[i] = !nxt_taken && pinDrive_ff[i];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fast_ff    <= 1'b0;
      extClk_ff  <= 1'b0;
      steps_ff   <= '0;
      unavail_ff <= 1'b0;
      pinOut_ff  <= '0;
      pinOe_ff   <= '0;
      taken_ff   <= 1'b0;
    end else begin
      fast_ff    <= nxt_fast;
      extClk_ff  <= nxt_extClk;
      steps_ff   <= nxt_steps;
      unavail_ff <= nxt_unavail;
      pinOut_ff  <= nxt_pinOut;
      pinOe_ff   <= nxt_pinOe;
      taken_ff   <= nxt_taken;
    end
  end

  // ****************************************************************
  // Control and pin outputs
  // ****************************************************************
  assign modClk64k         = fast_ff;
  assign externalRespClock = extClk_ff;
  assign demodPhaseSteps   = steps_ff;
  assign demodPhaseUnavail = unavail_ff;
  assign gpioOut           = pinOut_ff;
  assign gpioOe            = pinOe_ff;
  assign pinsTakenOver     = taken_ff;

endmodule
`default_nettype wire

// file: verif/respiration_gpio_config_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module respiration_gpio_config_asserts
  import resp_gpio_pkg::*;
#(
  parameter int NUM_PINS = 2
) (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    rstn,
  // Bus
  input wire logic [7:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  // Controls
  input wire logic                    respModEn,
  input wire logic                    respDemodEn,
  input wire logic                    modClk64k,
  input wire logic                    externalRespClock,
  input wire logic [PHASE_STEP_W-1:0] demodPhaseSteps,
  input wire logic                    demodPhaseUnavail,
  input wire logic [NUM_PINS-1:0]     gpioOut,
  input wire logic [NUM_PINS-1:0]     gpioOe,
  input wire logic                    pinsTakenOver
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  answer_next_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  unmapped_zero_a: assert property (!avs_waitrequest && $past(avs_read) &&
    !($past(avs_address) inside {8'h24, 8'h28, 8'h2C}) |-> avs_readdata == 0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("readdata upper bits not zero");
  taken_quiet_a: assert property (
    pinsTakenOver |-> gpioOe == 0 && gpioOut == 0)
    else $error("pins driven while taken over");
  taken_cause_a: assert property (pinsTakenOver |->
    externalRespClock && $past(respModEn || respDemodEn))
    else $error("takeover without cause");
  ext_no_fast_a: assert property (externalRespClock |-> !modClk64k)
    else $error("fast clock in external mode");
  unavail_fast_a: assert property (demodPhaseUnavail |-> modClk64k)
    else $error("phase unavailable at slow clock");
  fast_even_a: assert property (modClk64k |->
    demodPhaseSteps[0] == 1'b0 && demodPhaseSteps[4] == 1'b0)
    else $error("fast clock phase not an even step");

  cover property (pinsTakenOver);
  cover property (demodPhaseUnavail);
  cover property (!avs_waitrequest && $past(avs_write));
endmodule
bind respiration_gpio_config respiration_gpio_config_asserts #(
  .NUM_PINS(NUM_PINS)) chk (.core_clk(core_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .respModEn(respModEn), .respDemodEn(respDemodEn), .modClk64k(modClk64k),
  .externalRespClock(externalRespClock), .demodPhaseSteps(demodPhaseSteps),
  .demodPhaseUnavail(demodPhaseUnavail), .gpioOut(gpioOut), .gpioOe(gpioOe),
  .pinsTakenOver(pinsTakenOver));
`default_nettype wire

// file: verif/respiration_gpio_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module respiration_gpio_config_tb
  import resp_gpio_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic respModEn = 1'b0;
  logic respDemodEn = 1'b0;
  logic offsetCalEnable, modClk64k, externalRespClock, legDriveRefInternal;
  logic [PHASE_STEP_W-1:0] demodPhaseSteps;
  logic demodPhaseUnavail, pinsTakenOver;
  logic [1:0] gpioIn = 2'b10;
  logic [1:0] gpioOut, gpioOe;
  int fails = 0;
  int checks = 0;

  always #5 core_clk = ~core_clk;

  respiration_gpio_config DUT (.core_clk(core_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .respModEn(respModEn), .respDemodEn(respDemodEn),
    .offsetCalEnable(offsetCalEnable), .modClk64k(modClk64k),
    .externalRespClock(externalRespClock),
    .legDriveRefInternal(legDriveRefInternal),
    .demodPhaseSteps(demodPhaseSteps), .demodPhaseUnavail(demodPhaseUnavail),
    .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .pinsTakenOver(pinsTakenOver));

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    `CHK("wait cycles", 1, n - 1)
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Derived outputs lag the register by one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] be = 4'hF);
    logic [31:0] q;
    xfer(a, 1'b1, d, be, q);
    repeat (2) @(negedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] q;
    xfer(a, 1'b0, 8'h00, 4'hF, q);
    `CHK(nm, e, q)
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(8'h24, 32'h02, "first reset");
    rd(8'h28, 32'h03, "second reset");
    rd(8'h2C, 32'h0E, "pins reset");
    `CHK("ref internal", 1'b1, legDriveRefInternal)
    `CHK("oe reset", 2'b00, gpioOe)
    `CHK("cal reset", 1'b0, offsetCalEnable)
    `CHK("clk reset", 1'b0, modClk64k)
    `CHK("ext reset", 1'b0, externalRespClock)
    $display("test reset done");
  endtask

  task automatic t_second;
    wr(8'h28, 8'h86);
    `CHK("cal on", 1'b1, offsetCalEnable)
    `CHK("clk64", 1'b1, modClk64k)
    rd(8'h28, 32'h87, "second rd");
    wr(8'h28, 8'h78);
    `CHK("cal off", 1'b0, offsetCalEnable)
    `CHK("ref ext", 1'b0, legDriveRefInternal)
    rd(8'h28, 32'h01, "second fixed");
    wr(8'h28, 8'hFF, 4'hE);
    rd(8'h28, 32'h01, "no byteenable");
    $display("test second done");
  endtask

  task automatic t_phase;
    logic [PHASE_STEP_W-1:0] expSteps;
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 16; c++) begin
        wr(8'h28, f ? 8'h04 : 8'h00);
        wr(8'h24, {2'b00, c[3:0], 2'b10});
        // Steps of 11.25 degrees; 64 kHz doubles the step
        expSteps = f ? PHASE_STEP_W'(2 * (c % 8)) : PHASE_STEP_W'(c);
        `CHK("phase", expSteps, demodPhaseSteps)
        `CHK("unavail", (f == 1) && c[3], demodPhaseUnavail)
        `CHK("clk sel", f[0], modClk64k)
      end
    end
    $display("test phase done");
  endtask

  task automatic t_pins;
    wr(8'h2C, 8'h09);
    `CHK("oe pin0", 2'b01, gpioOe)
    `CHK("out old dir", 2'b00, gpioOut)
    wr(8'h2C, 8'h0B);
    `CHK("out pin0", 2'b01, gpioOut)
    rd(8'h2C, 32'h0A, "pin levels");
    @(posedge core_clk);
    gpioIn <= 2'b01;
    repeat (3) @(posedge core_clk);
    rd(8'h2C, 32'h09, "pin levels new");
    wr(8'h2C, 8'h03);
    `CHK("oe both", 2'b11, gpioOe)
    `CHK("input write dropped", 2'b01, gpioOut)
    wr(8'h2C, 8'h03);
    `CHK("out both", 2'b11, gpioOut)
    $display("test pins done");
  endtask

  task automatic t_take;
    wr(8'h28, 8'h04);
    @(posedge core_clk);
    respModEn <= 1'b1;
    wr(8'h24, 8'h03);
    `CHK("ext clock", 1'b1, externalRespClock)
    `CHK("clk ext mode", 1'b0, modClk64k)
    `CHK("taken", 1'b1, pinsTakenOver)
    `CHK("taken oe", 2'b00, gpioOe)
    `CHK("taken out", 2'b00, gpioOut)
    @(posedge core_clk);
    respModEn <= 1'b0;
    respDemodEn <= 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("taken demod", 1'b1, pinsTakenOver)
    @(posedge core_clk);
    respDemodEn <= 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("released oe", 2'b11, gpioOe)
    `CHK("kept out", 2'b11, gpioOut)
    wr(8'h24, 8'h02);
    `CHK("clk back", 1'b1, modClk64k)
    rd(8'h30, 32'h0, "unmapped rd");
    wr(8'h30, 8'hFF);
    rd(8'h28, 32'h05, "after unmapped wr");
    $display("test takeover done");
  endtask

  // Mid-run reset must restore the second and pin registers
  task automatic t_rereset;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK("oe in reset", 2'b00, gpioOe)
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(8'h2C, 32'h0D, "pins rereset");
    rd(8'h28, 32'h03, "second rereset");
    `CHK("out rereset", 2'b00, gpioOut)
    $display("test rereset done");
  endtask

  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_second();
    t_phase();
    t_pins();
    t_take();
    t_rereset();
    finish_test();
  end
endmodule
`default_nettype wire
